// ---- rtl/int_logic_branch_exec.v ----
// Decode and execute for wrapping add, conjunctions and branches.
// Assumes a fetch unit that presents one instruction with its address,
// holds it until taken, and follows pc_out after each step.
`timescale 1ns/1ns
`include "int_branch_regs.vh"
module int_logic_branch_exec
(
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Instruction in
    input wire instr_valid,
    input wire [31:0] instr,
    input wire [63:0] instr_addr,
    output wire instr_ready,
    // Program counter and status
    output reg [63:0] pc_out,
    output reg redirect,
    output reg nullified,
    output reg unsupported,
    output reg exception,
    // Debug read of the register file
    input wire [4:0] dbg_addr,
    output wire [63:0] dbg_data
);
    // ********************
    // Pipeline phases
    // ********************
    localparam ST_READ = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg state_reg;
    reg [31:0] ir_reg;
    reg [63:0] ia_reg;
    reg br_pending_reg;
    reg [63:0] br_target_reg;
    reg kill_next_reg;
    reg [4:0] rd_a;
    reg [4:0] rd_b;
    wire [63:0] src_a;
    wire [63:0] src_b;
    reg wr_en;
    reg [4:0] wr_addr;
    reg [63:0] wr_data;
    reg is_branch;
    reg is_likely;
    reg cond;
    reg known;

    // Field extraction [RULE16]
    wire [5:0] op = ir_reg[31:26];
    wire [4:0] f_one = ir_reg[25:21];
    wire [4:0] f_two = ir_reg[20:16];
    wire [4:0] f_dst = ir_reg[15:11];
    wire [5:0] fn = ir_reg[5:0];
    wire [15:0] imm = ir_reg[15:0];

    // Sign extend the low word of a value
    function [63:0] sext_word;
        input [63:0] v;
        begin
            sext_word = {{32{v[31]}}, v[31:0]};
        end
    endfunction

    // Branch target: delay slot address plus offset shifted by two
    function [63:0] br_target;
        input [63:0] addr;
        input [15:0] off;
        begin
            br_target = addr + `SLOT_STEP + {{46{off[15]}}, off, 2'b00};
        end
    endfunction

    assign instr_ready = (state_reg == ST_READ);

    // ********************
    // Register file
    // ********************
    // Port A is shared with debug while idle; reads land one cycle later
    always @*
    begin
        // Debug owns port A unless an instruction is offered in the read phase
        rd_a = (state_reg == ST_READ && instr_valid) ? instr[25:21]
            : dbg_addr;
        rd_b = instr[20:16];
    end

    general_register_file #(.WIDTH(64)) u_regs
    (
        .clk(clk),
        .rst_b(rst_b),
        .rd_addr_a(rd_a),
        .rd_addr_b(rd_b),
        .rd_data_a(src_a),
        .rd_data_b(src_b),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );
    assign dbg_data = src_a;

    // ********************
    // Execute decode
    // ********************
    // Operand bits 63..31 are trusted to be sign-extended for the add [RULE2]
    always @*
    begin
        wr_en = 1'b0;
        wr_addr = 5'h00;
        wr_data = 64'h0000000000000000;
        is_branch = 1'b0;
        is_likely = 1'b0;
        cond = 1'b0;
        known = 1'b1;
        if (state_reg == ST_EXEC)
        begin
            case (op)
                `OP_SPECIAL:
                begin
                    if (fn == `FN_ADD_WRAP)
                    begin
                        wr_en = 1'b1;
                        wr_addr = f_dst;
                        wr_data = sext_word(src_a + src_b); // [RULE1]
                    end
                    else if (fn == `FN_AND_REG)
                    begin
                        wr_en = 1'b1;
                        wr_addr = f_dst;
                        wr_data = src_a & src_b; // [RULE3]
                    end
                    else
                        known = 1'b0;
                end
                `OP_AND_IMM:
                begin
                    wr_en = 1'b1;
                    wr_addr = f_two;
                    wr_data = src_a & {48'h000000000000, imm}; // [RULE4]
                end
                `OP_BR_EQUAL, `OP_BR_EQUAL_LIKELY:
                begin
                    is_branch = 1'b1;
                    cond = (src_a == src_b); // [RULE8] [RULE9]
                    is_likely = (op == `OP_BR_EQUAL_LIKELY); // [RULE9]
                end
                `OP_REG_IMM_CLASS:
                begin
                    case (f_two)
                        `RI_NONNEG:
                        begin
                            is_branch = 1'b1;
                            cond = ~src_a[63]; // [RULE10]
                        end
                        `RI_NONNEG_LINK, `RI_NONNEG_LINK_LIKELY:
                        begin
                            is_branch = 1'b1;
                            cond = ~src_a[63];
                            is_likely = (f_two == `RI_NONNEG_LINK_LIKELY);
                            // Link written whether taken or not [RULE11] [RULE12]
                            wr_en = 1'b1;
                            wr_addr = `LINK_REG;
                            wr_data = ia_reg + `LINK_STEP; // [RULE13]
                        end
                        default:
                            known = 1'b0;
                    endcase
                end
                default:
                    known = 1'b0;
            endcase
            // A killed delay slot writes nothing [RULE7] [RULE17]
            if (kill_next_reg)
            begin
                wr_en = 1'b0;
                is_branch = 1'b0;
            end
        end
    end

    // ********************
    // Sequencing
    // ********************
    // Branch resolved here, applied after the next step [RULE15]
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_READ;
            ir_reg <= 32'h00000000;
            ia_reg <= 64'h0000000000000000;
            br_pending_reg <= 1'b0;
            br_target_reg <= 64'h0000000000000000;
            kill_next_reg <= 1'b0;
            pc_out <= `PC_RESET;
            redirect <= 1'b0;
            nullified <= 1'b0;
            unsupported <= 1'b0;
            exception <= 1'b0; // Never raised [RULE18]
        end
        else
        begin
            redirect <= 1'b0;
            nullified <= 1'b0;
            unsupported <= 1'b0;
            case (state_reg)
                ST_READ:
                begin
                    if (instr_valid)
                    begin
                        ir_reg <= instr;
                        ia_reg <= instr_addr;
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    state_reg <= ST_READ;
                    nullified <= kill_next_reg;
                    unsupported <= ~known & ~kill_next_reg;
                    kill_next_reg <= 1'b0;
                    // Slot always runs before the jump [RULE6]
                    if (br_pending_reg)
                    begin
                        pc_out <= br_target_reg;
                        redirect <= 1'b1;
                        br_pending_reg <= 1'b0;
                    end
                    else
                        pc_out <= ia_reg + `SLOT_STEP;
                    if (is_branch)
                    begin
                        br_pending_reg <= cond;
                        br_target_reg <= br_target(ia_reg, imm); // [RULE5]
                        kill_next_reg <= is_likely & ~cond; // [RULE7]
                    end
                end
                default:
                    state_reg <= ST_READ;
            endcase
        end
    end
endmodule

// ---- rtl/int_branch_regs.vh ----
// Constants for the integer add, conjunction and branch execute block.
// Assumes a 32-bit instruction word and 64-bit general registers.
// Contract
// [RULE1] Wrapping add: sign-extend low word sum
// [RULE2] Software gives sign-extended add operands
// [RULE3] Register conjunction over all 64 bits
// [RULE4] Immediate conjunction, zero-extended, into second source
// [RULE5] Target is delay slot plus offset times four
// [RULE6] Plain branches always run the delay slot
// [RULE7] Likely branches nullify slot when not taken
// [RULE8] Opcode 000100 branches on 64-bit equality
// [RULE9] Equality likely shares condition, nullifies slot
// [RULE10] Code 00001 branches when sign bit clear
// [RULE11] Code 10001 links register 31 always
// [RULE12] Code 10011 links and nullifies when untaken
// [RULE13] Link value is branch address plus eight
// [RULE14] Software never tests register 31 when linking
// [RULE15] Evaluate at branch, redirect one step later
// [RULE16] Fixed instruction field positions
// [RULE17] Nullified slot makes no architectural change
// [RULE18] No exception from any of these
`ifndef INT_BRANCH_REGS_VH
`define INT_BRANCH_REGS_VH
`define OP_SPECIAL 6'h00
`define OP_REG_IMM_CLASS 6'h01
`define OP_BR_EQUAL 6'h04
`define OP_BR_EQUAL_LIKELY 6'h14
`define OP_AND_IMM 6'h0c
`define FN_ADD_WRAP 6'h21
`define FN_AND_REG 6'h24
`define RI_NONNEG 5'h01
`define RI_NONNEG_LINK 5'h11
`define RI_NONNEG_LINK_LIKELY 5'h13
`define LINK_REG 5'h1f
`define LINK_STEP 64'h0000000000000008
`define SLOT_STEP 64'h0000000000000004
`define PC_RESET 64'h0000000000000000
`endif

// ---- rtl/general_register_file.v ----
// Register file of 32 general registers, 64 bits, two read, one write.
// Assumes one clock; register zero reads as zero; reads are registered.
`timescale 1ns/1ns
module general_register_file
#(
    parameter WIDTH = 64
)
(
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Read ports
    input wire [4:0] rd_addr_a,
    input wire [4:0] rd_addr_b,
    output reg [WIDTH-1:0] rd_data_a,
    output reg [WIDTH-1:0] rd_data_b,
    // Write port
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [WIDTH-1:0] wr_data
);
    reg [WIDTH-1:0] mem [0:31];
    integer i;

    // ********************
    // Storage and read
    // ********************
    // Write-first bypass so a read sees a same-cycle write
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (i = 0; i < 32; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
            rd_data_a <= {WIDTH{1'b0}};
            rd_data_b <= {WIDTH{1'b0}};
        end
        else
        begin
            if (wr_en && wr_addr != 5'h00)
                mem[wr_addr] <= wr_data;
            if (rd_addr_a == 5'h00)
                rd_data_a <= {WIDTH{1'b0}};
            else if (wr_en && wr_addr == rd_addr_a)
                rd_data_a <= wr_data;
            else
                rd_data_a <= mem[rd_addr_a];
            if (rd_addr_b == 5'h00)
                rd_data_b <= {WIDTH{1'b0}};
            else if (wr_en && wr_addr == rd_addr_b)
                rd_data_b <= wr_data;
            else
                rd_data_b <= mem[rd_addr_b];
        end
    end
endmodule

// ---- bench/int_exec_checker.sv ----
// Port-level checker for the integer add, conjunction and branch block.
// Assumes one clock and a step of two edges from take to result.
`timescale 1ns/1ns
module int_exec_checker
(
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Handshake and status
    input wire instr_valid,
    input wire instr_ready,
    input wire [63:0] pc_out,
    input wire redirect,
    input wire nullified,
    input wire unsupported,
    input wire exception
);
    // ****************
    // Step timing
    // ****************
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Ready falls for the execute cycle, then returns
    ready_drop_a:
        assert property (instr_valid && instr_ready |=> !instr_ready)
        else $error("ready high in execute cycle");
    ready_back_a:
        assert property (instr_valid && instr_ready |=> ##1 instr_ready)
        else $error("ready not back after step");
    // Program counter only moves two edges after a take
    pc_hold_a:
        assert property (!$past(instr_valid && instr_ready, 2)
            |-> $stable(pc_out))
        else $error("pc moved without a step");
    redirect_cause_a:
        assert property (redirect |-> $past(instr_valid && instr_ready, 2))
        else $error("redirect without a step");
    // ****************
    // Status pulses
    // ****************
    null_pulse_a:
        assert property (nullified |=> !nullified)
        else $error("nullified longer than one cycle");
    null_quiet_a:
        assert property (nullified |-> !redirect && !unsupported)
        else $error("nullified slot had an effect");
    unsup_cause_a:
        assert property (unsupported |-> $past(instr_valid && instr_ready, 2))
        else $error("unsupported without a step");
    exc_zero_a:
        assert property (!exception)
        else $error("exception raised");
endmodule
bind int_logic_branch_exec int_exec_checker chk (.clk(clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .pc_out(pc_out),
    .redirect(redirect), .nullified(nullified), .unsupported(unsupported),
    .exception(exception));

// ---- bench/int_logic_branch_exec_tb_top.sv ----
// Self-checking bench for the integer add, conjunction and branch block.
// Assumes registers start at zero; link register seeds all data.
`timescale 1ns/1ns
module int_logic_branch_exec_tb_top;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg instr_valid = 1'b0;
    reg [31:0] instr = 32'h0;
    reg [63:0] instr_addr = 64'h0;
    reg [4:0] dbg_addr = 5'h0;
    wire instr_ready, redirect, nullified, unsupported, exception;
    wire [63:0] pc_out, dbg_data;
    integer error_cnt = 0;
    integer n_checks = 0;
    integer cyc = 0;
    reg [63:0] link_exp;
    reg [63:0] v;
    // 250 MHz core clock
    always #2 clk = ~clk;
    int_logic_branch_exec DUT (.clk(clk), .rst_b(rst_b),
        .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
        .instr_ready(instr_ready), .pc_out(pc_out), .redirect(redirect),
        .nullified(nullified), .unsupported(unsupported),
        .exception(exception), .dbg_addr(dbg_addr), .dbg_data(dbg_data));
    // ****************
    // Helpers
    // ****************
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt = error_cnt + 1;
            complete_run;
        end
    end
    task chk(input string nm, input [63:0] seen, input [63:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    function [31:0] rr(input [5:0] fn, input [4:0] s, t, d);
        rr = {6'h00, s, t, d, 5'h00, fn};
    endfunction
    function [31:0] ri(input [5:0] op, input [4:0] s, t, input [15:0] k);
        ri = {op, s, t, k};
    endfunction
    // Entered at a falling edge; leaves at the one after the result
    task step(input [31:0] w, input [63:0] a);
        integer n;
        begin
            instr = w;
            instr_addr = a;
            instr_valid = 1'b1;
            n = 0;
            while (instr_ready !== 1'b1 && n < 20)
            begin
                n = n + 1;
                @(negedge clk);
            end
            @(negedge clk);
            instr_valid = 1'b0;
            @(negedge clk);
        end
    endtask
    task rd(input [4:0] r);
        begin
            dbg_addr = r;
            @(negedge clk);
            v = dbg_data;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    // Taken link branch seeds register 31
    task t_link;
        begin
            step(ri(6'h01, 5'd0, 5'h11, 16'h0004), 64'h4000ffe8);
            step(rr(6'h24, 5'd0, 5'd0, 5'd6), 64'h4000ffec);
            chk("redirect", 64'(redirect), 64'h1);
            chk("target", pc_out, 64'h4000fffc);
            rd(5'd31);
            chk("link", v, 64'h4000fff0);
            $display("link test done");
        end
    endtask
    // Add wraps and sign-extends; conjunctions; foreign opcode
    task t_arith;
        begin
            step(rr(6'h21, 5'd31, 5'd31, 5'd1), 64'h100);
            step(ri(6'h0c, 5'd1, 5'd3, 16'h1234), 64'h104);
            step(rr(6'h24, 5'd1, 5'd31, 5'd4), 64'h108);
            step(32'hfc000000, 64'h10c);
            chk("unsupported", 64'(unsupported), 64'h1);
            rd(5'd1);
            chk("add", v, 64'hffffffff8001ffe0);
            rd(5'd3);
            chk("and imm", v, 64'h1220);
            rd(5'd4);
            chk("and reg", v, 64'hffe0);
            $display("arith test done");
        end
    endtask
    // Branch, then slot copying r31 into r6; negative offset
    task br(input [31:0] w, input tk, input lk, input ln);
        begin
            step(rr(6'h24, 5'd0, 5'd0, 5'd6), 64'h1ff8);
            if (ln)
                link_exp = 64'h2008;
            step(w, 64'h2000);
            step(rr(6'h24, 5'd31, 5'd31, 5'd6), 64'h2004);
            chk("redirect", 64'(redirect), 64'(tk));
            chk("nullified", 64'(nullified), 64'(lk & !tk));
            chk("pc", pc_out, tk ? 64'h1ffc : 64'h2008);
            rd(5'd6);
            chk("slot", v, (lk & !tk) ? 64'h0 : link_exp);
            rd(5'd31);
            chk("link", v, link_exp);
            $display("branch test done");
        end
    endtask
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        link_exp = 64'h4000fff0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_link;
        t_arith;
        br(ri(6'h04, 5'd0, 5'd0, 16'hfffe), 1, 0, 0);
        br(ri(6'h04, 5'd1, 5'd0, 16'hfffe), 0, 0, 0);
        br(ri(6'h14, 5'd0, 5'd0, 16'hfffe), 1, 1, 0);
        br(ri(6'h14, 5'd1, 5'd0, 16'hfffe), 0, 1, 0);
        br(ri(6'h01, 5'd0, 5'h01, 16'hfffe), 1, 0, 0);
        br(ri(6'h01, 5'd1, 5'h01, 16'hfffe), 0, 0, 0);
        br(ri(6'h01, 5'd1, 5'h11, 16'hfffe), 0, 0, 1);
        br(ri(6'h01, 5'd1, 5'h13, 16'hfffe), 0, 1, 1);
        complete_run;
    end
endmodule
